/* rtl/ufc_defines.vh */
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH
`define UFC_REG_ADDR      8'ha9
`define UFC_RESET_VAL     8'h0c
`define UFC_BIT_MCE       7
`define UFC_BIT_PT_HI     6
`define UFC_BIT_PT_LO     5
`define UFC_BIT_PE        4
`define UFC_BIT_DL_HI     3
`define UFC_BIT_DL_LO     2
`define UFC_BIT_XBE       1
`define UFC_BIT_SBL       0
`define UFC_PT_ODD        2'h0
`define UFC_PT_EVEN       2'h1
`define UFC_PT_MARK       2'h2
`define UFC_PT_SPACE      2'h3
`define UFC_DIV_DEFAULT   16'h0364
`endif

/* rtl/ufc_parity.v */
`timescale 1ns/1ps
`include "ufc_defines.vh"
module ufc_parity (
  input  wire [7:0] data,
  input  wire [1:0] len_sel,
  input  wire [1:0] kind,
  output reg        par
);
  reg [7:0] m;
  always @* begin
    m = data & (8'h1f | ({1'b0, {3{1'b0}}, 4'h0} ) |
        (len_sel >= 2'h1 ? 8'h20 : 8'h00) | (len_sel >= 2'h2 ? 8'h40 : 8'h00) |
        (len_sel == 2'h3 ? 8'h80 : 8'h00));
    case (kind)
      `UFC_PT_ODD:  par = ~(^m);
      `UFC_PT_EVEN: par = ^m;
      `UFC_PT_MARK: par = 1'b1;
      default:      par = 1'b0;
    endcase
  end
endmodule

/* rtl/ufc_top.v */
// Function
// - Receive-complete needs the first stop bit one; multiprocessor mode also needs extra-bit enable and extra bit one.
// - Parity kind field: 00 odd, 01 even, 10 mark, 11 space.
// - Parity enable adds parity on transmit and checks it on receive.
// - Length field sets 5, 6, 7 or 8 data bits.
// - Extra-bit enable appends software extra bit after data.
// - Long stop gives two bit times, or 1.5 for five bits.
`timescale 1ns/1ps
`include "ufc_defines.vh"
module ufc_top #(
  parameter [15:0] BIT_DIV = `UFC_DIV_DEFAULT
) (
  input  wire       clock,
  input  wire       rst,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire [7:0] tx_data,
  input  wire       tx_appended_bit_value,
  input  wire       tx_start,
  output reg        tx_busy,
  output reg        txd,
  input  wire       rxd,
  output reg  [7:0] rx_data,
  output reg        rx_appended_bit,
  output reg        rx_complete_flag,
  output reg        rx_parity_error,
  input  wire       rx_flag_clear
);
  localparam S_IDLE = 3'h0;
  localparam S_DATA = 3'h1;
  localparam S_PAR  = 3'h2;
  localparam S_XB   = 3'h3;
  localparam S_STOP = 3'h4;
  localparam S_STRT = 3'h5;

  reg [7:0] ctl_q;
  wire       mce  = ctl_q[`UFC_BIT_MCE];
  wire [1:0] pkind = ctl_q[`UFC_BIT_PT_HI:`UFC_BIT_PT_LO];
  wire       pe   = ctl_q[`UFC_BIT_PE];
  wire [1:0] dl   = ctl_q[`UFC_BIT_DL_HI:`UFC_BIT_DL_LO];
  wire       xbe  = ctl_q[`UFC_BIT_XBE];
  wire       sbl  = ctl_q[`UFC_BIT_SBL];

  function [3:0] nbits;
    input [1:0] s;
    begin
      nbits = {2'b00, s} + 4'h5;
    end
  endfunction

  function [2:0] stop_halves;
    input l;
    input [1:0] s;
    begin
      stop_halves = !l ? 3'h2 : (s == 2'h0 ? 3'h3 : 3'h4);
    end
  endfunction

  always @(posedge clock) begin
    if (rst) begin
      ctl_q <= `UFC_RESET_VAL;
      sfr_rdata <= 8'h00;
    end else begin
      if (sfr_wr && sfr_addr == `UFC_REG_ADDR)
        ctl_q <= sfr_wdata & 8'hdf | (sfr_wdata[5] ? 8'h20 : 8'h00);
      sfr_rdata <= (sfr_rd && sfr_addr == `UFC_REG_ADDR) ? ctl_q : 8'h00;
    end
  end

  reg [7:0] tsh_q;
  reg       txb_q;
  wire      tpar;
  ufc_parity u_tpar (
    .data    (tx_data),
    .len_sel (dl),
    .kind    (pkind),
    .par     (tpar)
  );
  reg        tpar_q;
  reg [2:0]  ts_q;
  reg [3:0]  tcnt_q;
  reg [15:0] tdiv_q;
  wire [15:0] half = {1'b0, BIT_DIV[15:1]};
  always @(posedge clock) begin
    if (rst) begin
      ts_q <= S_IDLE;
      txd <= 1'b1;
      tx_busy <= 1'b0;
      tsh_q <= 8'h00;
      txb_q <= 1'b0;
      tpar_q <= 1'b0;
      tcnt_q <= 4'h0;
      tdiv_q <= 16'h0000;
    end else if (ts_q == S_IDLE) begin
      txd <= 1'b1;
      if (tx_start) begin
        tsh_q <= tx_data;
        txb_q <= tx_appended_bit_value;
        tpar_q <= tpar;
        ts_q <= S_STRT;
        tx_busy <= 1'b1;
        txd <= 1'b0;
        tdiv_q <= BIT_DIV - 16'h0001;
      end
    end else if (tdiv_q != 16'h0000) begin
      tdiv_q <= tdiv_q - 16'h0001;
    end else begin
      tdiv_q <= BIT_DIV - 16'h0001;
      case (ts_q)
        S_STRT: begin
          ts_q <= S_DATA;
          tcnt_q <= nbits(dl) - 4'h1;
          txd <= tsh_q[0];
          tsh_q <= {1'b0, tsh_q[7:1]};
        end
        S_DATA: begin
          if (tcnt_q != 4'h0) begin
            tcnt_q <= tcnt_q - 4'h1;
            txd <= tsh_q[0];
            tsh_q <= {1'b0, tsh_q[7:1]};
          end else if (pe) begin
            ts_q <= S_PAR;
            txd <= tpar_q;
          end else if (xbe) begin
            ts_q <= S_XB;
            txd <= txb_q;
          end else begin
            ts_q <= S_STOP;
            txd <= 1'b1;
            tcnt_q <= {1'b0, stop_halves(sbl, dl)} - 4'h1;
            tdiv_q <= half - 16'h0001;
          end
        end
        S_PAR: begin
          if (xbe) begin
            ts_q <= S_XB;
            txd <= txb_q;
          end else begin
            ts_q <= S_STOP;
            txd <= 1'b1;
            tcnt_q <= {1'b0, stop_halves(sbl, dl)} - 4'h1;
            tdiv_q <= half - 16'h0001;
          end
        end
        S_XB: begin
          ts_q <= S_STOP;
          txd <= 1'b1;
          tcnt_q <= {1'b0, stop_halves(sbl, dl)} - 4'h1;
          tdiv_q <= half - 16'h0001;
        end
        S_STOP: begin
          if (tcnt_q != 4'h0) begin
            tcnt_q <= tcnt_q - 4'h1;
            tdiv_q <= half - 16'h0001;
          end else begin
            ts_q <= S_IDLE;
            tx_busy <= 1'b0;
          end
        end
        default: ts_q <= S_IDLE;
      endcase
    end
  end

  reg rx_m_q;
  reg rx_s_q;
  always @(posedge clock) begin
    if (rst) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= rxd;
      rx_s_q <= rx_m_q;
    end
  end

  reg [2:0]  rs_q;
  reg [3:0]  rcnt_q;
  reg [15:0] rdiv_q;
  reg [7:0]  rsh_q;
  reg        rpar_q;
  reg        rxb_q;
  wire [7:0] rjust = rsh_q >> (4'h8 - nbits(dl));
  wire       rexp;
  ufc_parity u_rpar (
    .data    (rjust),
    .len_sel (dl),
    .kind    (pkind),
    .par     (rexp)
  );
  wire frame_done = (rs_q == S_STOP) && (rdiv_q == 16'h0000);
  wire ok = rx_s_q && (!mce || (xbe && rxb_q));
  always @(posedge clock) begin
    if (rst) begin
      rs_q <= S_IDLE;
      rcnt_q <= 4'h0;
      rdiv_q <= 16'h0000;
      rsh_q <= 8'h00;
      rpar_q <= 1'b0;
      rxb_q <= 1'b1;
      rx_data <= 8'h00;
      rx_appended_bit <= 1'b0;
      rx_complete_flag <= 1'b0;
      rx_parity_error <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      if (frame_done && ok) begin
        rx_complete_flag <= 1'b1;
        rx_data <= rjust;
        rx_appended_bit <= rxb_q;
        rx_parity_error <= pe && (rpar_q != rexp);
      end else if (rx_flag_clear) begin
        rx_complete_flag <= 1'b0;
      end
      if (rs_q == S_IDLE) begin
        rxb_q <= 1'b1;
        if (!rx_s_q) begin
          rs_q <= S_STRT;
          rdiv_q <= half;
        end
      end else if (rdiv_q != 16'h0000) begin
        rdiv_q <= rdiv_q - 16'h0001;
      end else begin
        rdiv_q <= BIT_DIV - 16'h0001;
        case (rs_q)
          S_STRT: begin
            if (rx_s_q) begin
              rs_q <= S_IDLE;
            end else begin
              rs_q <= S_DATA;
              rcnt_q <= nbits(dl);
            end
          end
          S_DATA: begin
            if (rcnt_q != 4'h0) begin
              rcnt_q <= rcnt_q - 4'h1;
              rsh_q <= {rx_s_q, rsh_q[7:1]};
              if (rcnt_q == 4'h1)
                rs_q <= pe ? S_PAR : (xbe ? S_XB : S_STOP);
            end
          end
          S_PAR: begin
            rpar_q <= rx_s_q;
            rs_q <= xbe ? S_XB : S_STOP;
          end
          S_XB: begin
            rxb_q <= rx_s_q;
            rs_q <= S_STOP;
          end
          S_STOP: rs_q <= S_IDLE;
          default: rs_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule

/* sim/ufc_chk.sv */
`timescale 1ns/1ps
module ufc_chk (
  input logic clock,
  input logic rst,
  input logic tx_start,
  input logic tx_busy,
  input logic txd,
  input logic rxd,
  input logic rx_complete_flag,
  input logic rx_flag_clear
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_take; tx_start && !tx_busy |=> tx_busy && !txd; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_start; $rose(tx_busy) |-> !txd [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit short");
  property p_stop; $fell(tx_busy) |-> $past(txd, 8); endproperty
  a_stop: assert property (p_stop) else $error("stop bit low");
  property p_idle; !tx_busy |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  // Flag can only follow a high line
  property p_flag; $rose(rx_complete_flag) |-> $past(rxd); endproperty
  a_flag: assert property (p_flag) else $error("flag without stop");
  // Sticky until software clears it
  property p_hold; rx_complete_flag && !rx_flag_clear |=> rx_complete_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");
  c_tx: cover property ($rose(tx_busy));
  c_rx: cover property ($rose(rx_complete_flag));
  c_clr: cover property ($fell(rx_complete_flag));
endmodule
bind ufc_top ufc_chk ufc_chk_inst (.*);

/* sim/ufc_peer.sv */
`timescale 1ns/1ps
module ufc_peer (
  input  logic clock,
  output logic rxd
);
  initial rxd = 1'b1;
  // bits go out LSB first, line returns high
  task automatic send(input logic [15:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd = f[i];
      repeat (16) @(negedge clock);
    end
    rxd = 1'b1;
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr = 8'ha9;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_appended_bit_value = 1'b0;
  logic       tx_start = 1'b0;
  logic       rx_flag_clear = 1'b0;
  wire  [7:0] sfr_rdata, rx_data;
  wire        tx_busy, txd, rxd, rx_appended_bit, rx_complete_flag, rx_parity_error;
  int         miscompares = 0;
  int         num_checks = 0;
  // Short bit time keeps frames to a few hundred cycles
  ufc_top #(.BIT_DIV(16'h0010)) ufc_top_inst (.*);
  ufc_peer ufc_peer_inst (.clock, .rxd);
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [15:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp, "reg read");
    // Let an edge pass so back-to-back reads keep the strobe clean
    @(negedge clock);
  endtask
  // Frame from config: start, data, parity, extra, one stop
  function automatic logic [15:0] frm(input logic [7:0] c, d, input logic xb, output int n);
    int len;
    len = c[3:2] + 5;
    frm = '0;
    n = 1;
    for (int i = 0; i < len; i++) begin
      frm[n] = d[i];
      n++;
    end
    if (c[4]) begin
      frm[n] = c[6] ? !c[5] : (^(d & ~(8'hff << len)) ^ !c[5]);
      n++;
    end
    if (c[1]) begin
      frm[n] = xb;
      n++;
    end
    frm[n] = 1'b1;
  endfunction
  task automatic tx(input logic [7:0] c, d, input logic xb);
    logic [15:0] f, got;
    int n, cnt;
    f = frm(c, d, xb, n);
    got = '0;
    cnt = 0;
    wr(8'ha9, c);
    tx_data = d;
    tx_appended_bit_value = xb;
    tx_start = 1'b1;
    @(negedge clock);
    tx_start = 1'b0;
    // Sample each bit at its middle
    while (tx_busy === 1'b1 && cnt < 999) begin
      if (cnt % 16 == 8) got[cnt / 16] = txd;
      cnt++;
      @(negedge clock);
    end
    chk(got & ~(16'hffff << (n + 1)), f & ~(16'hffff << (n + 1)), "tx frame");
    chk(cnt, n * 16 + (c[0] ? (c[3:2] == 0 ? 24 : 32) : 16), "tx length");
  endtask
  task automatic rx(input logic [7:0] c, d, input logic xb, flip, ok);
    logic [15:0] f;
    int n;
    f = frm(c, d, xb, n);
    f[n - 1] ^= flip;
    wr(8'ha9, c);
    ufc_peer_inst.send(f, n + 1);
    chk(rx_complete_flag, ok, "rx flag");
    if (ok) begin
      chk(rx_data, d, "rx data");
      chk(rx_parity_error, flip, "rx parity");
      if (c[1])
        chk(rx_appended_bit, xb, "rx extra bit");
    end
    rx_flag_clear = 1'b1;
    @(negedge clock);
    rx_flag_clear = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    rd(8'ha9, 8'h0c);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    rd(8'ha9, 8'h0c);
    // Every parity kind and length, extra bit and long stop mixed in
    for (int k = 0; k < 4; k++) tx({1'b0, k[1:0], 1'b1, k[1:0], k[0], k[1]}, 8'h5a >> k, k[1]);
    rd(8'ha9, 8'h7f);
    tx(8'h0c, 8'h96, 1'b0);
    // Five bits with long stop gives the 1.5 bit stop
    tx(8'h13, 8'h15, 1'b1);
    rx(8'h3c, 8'ha7, 1'b0, 1'b0, 1'b1);
    rx(8'h3c, 8'ha7, 1'b0, 1'b1, 1'b1);
    rx(8'h8e, 8'h33, 1'b0, 1'b0, 1'b0);
    rx(8'h8e, 8'h33, 1'b1, 1'b0, 1'b1);
    rx(8'h0e, 8'h33, 1'b0, 1'b0, 1'b1);
    rx(8'h5c, 8'h3c, 1'b0, 1'b1, 1'b1);
    rx(8'h11, 8'h15, 1'b0, 1'b0, 1'b1);
    give_verdict;
  end
endmodule
